// ==== hw/sar_adc_consts.svh ====
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ==========================================================
// Clock and timing figures
`define CLK_PERIOD_NS   10
`define CONV_MAX_NS     3700
`define ACQ_MIN_NS      1400
`define PWR_UP_NS       1000
`define RIN_OHMS        1500
`define SAMPLE_CAP_PF   20
`define PULSE_MIN_NS    30
`define SCLK_HALF_NS    80
`define INT_CLK_NS      250

// ==========================================================
// Derived cycle counts
`define CYC_MIN(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(ns)     ((ns) / `CLK_PERIOD_NS)
`define CONV_MAX_CYC    `CYC_MAX(`CONV_MAX_NS)
`define PULSE_MIN_CYC   `CYC_MIN(`PULSE_MIN_NS)
`define SCLK_HALF_CYC   `CYC_MIN(`SCLK_HALF_NS)
`define INT_CLK_DIV     `CYC_MAX(`INT_CLK_NS)
`define SYNC_SLACK_CYC  6

// ==========================================================
// Result format
`define RESULT_BITS     12
`define RESULT_MSB      11
`define FIFO_DEPTH      4

`endif

// ==== hw/sar_pkg.sv ====
package sar_pkg;
  typedef logic [11:0] result_t;

  typedef enum logic [1:0] {
    DEV_SHUTDOWN,
    DEV_TRACK,
    DEV_CONVERT,
    DEV_READOUT
  } dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_PRE_HIGH,
    HOST_PRE_LOW,
    HOST_ACQUIRE,
    HOST_CONV_WAIT,
    HOST_READ,
    HOST_PUSH
  } host_state_t;
endpackage : sar_pkg

// ==== hw/sar_link_if.sv ====
interface sar_link_if;
  logic conversion_start_pin;
  logic serial_clock_pin;
  logic serial_data_out_o;
  logic serial_data_out_oe;
  logic serial_data_out;

  // ==========================================================
  // Wire level of the data pin; released pin shows the inverse of the last bit
  assign serial_data_out = serial_data_out_oe ? serial_data_out_o : ~serial_data_out_o;

  modport device (
    input  conversion_start_pin,
    input  serial_clock_pin,
    output serial_data_out_o,
    output serial_data_out_oe
  );

  modport host (
    output conversion_start_pin,
    output serial_clock_pin,
    input  serial_data_out
  );
endinterface : sar_link_if

// ==== hw/sar_adc_device.sv ====
`include "sar_adc_consts.svh"

module sar_adc_device (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  sar_link_if.device           link,
  input  wire sar_pkg::result_t i_ch1_code,
  input  wire sar_pkg::result_t i_ch2_code,
  output logic                 o_tracking,
  output logic                 o_second_channel,
  output logic                 o_shutdown,
  output sar_pkg::result_t     o_result,
  output logic                 o_result_valid
);
  import sar_pkg::*;

  localparam int DIV = `INT_CLK_DIV;

  dev_state_t state_reg;
  logic       start_meta_reg;
  logic       start_sync_reg;
  logic       start_prev_reg;
  logic       sclk_meta_reg;
  logic       sclk_sync_reg;
  logic       sclk_prev_reg;
  logic       start_rise;
  logic       start_fall;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       second_reg;
  result_t    held_reg;
  result_t    sar_reg;
  result_t    shift_reg;
  logic [3:0] bit_idx_reg;
  logic [4:0] div_reg;
  logic       int_tick;
  logic       conv_done;
  logic [3:0] bits_read_reg;
  logic       dout_reg;
  logic       dout_oe_reg;
  result_t    final_code;

  // ==========================================================
  // Pin synchronisers and edge detection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_meta_reg <= 1'b0;
      start_sync_reg <= 1'b0;
      start_prev_reg <= 1'b0;
      sclk_meta_reg  <= 1'b0;
      sclk_sync_reg  <= 1'b0;
      sclk_prev_reg  <= 1'b0;
    end else begin
      start_meta_reg <= link.conversion_start_pin;
      start_sync_reg <= start_meta_reg;
      start_prev_reg <= start_sync_reg;
      sclk_meta_reg  <= link.serial_clock_pin;
      sclk_sync_reg  <= sclk_meta_reg;
      sclk_prev_reg  <= sclk_sync_reg;
    end
  end

  assign start_rise = start_sync_reg & ~start_prev_reg;
  assign start_fall = ~start_sync_reg & start_prev_reg;
  assign sclk_rise  = sclk_sync_reg & ~sclk_prev_reg;
  assign sclk_fall  = ~sclk_sync_reg & sclk_prev_reg;

  // ==========================================================
  // Internal conversion clock, 4 MHz enable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 5'h0;
    end else if (state_reg != DEV_CONVERT || int_tick) begin
      div_reg <= 5'h0;
    end else begin
      div_reg <= div_reg + 5'h1;
    end
  end

  assign int_tick  = (state_reg == DEV_CONVERT) && (div_reg == 5'(DIV - 1));
  assign conv_done = int_tick && (bit_idx_reg == 4'h0);

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= DEV_SHUTDOWN;
    end else if (start_rise) begin
      state_reg <= DEV_TRACK;
    end else begin
      case (state_reg)
        DEV_TRACK: begin
          if (start_fall) begin
            state_reg <= DEV_CONVERT;
          end
        end
        DEV_CONVERT: begin
          if (conv_done) begin
            state_reg <= DEV_READOUT;
          end
        end
        DEV_READOUT: begin
          state_reg <= DEV_READOUT;
        end
        default: begin
          state_reg <= DEV_SHUTDOWN;
        end
      endcase
    end
  end

  // ==========================================================
  // Channel selection at each start rise
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      second_reg <= 1'b0;
    end else if (start_rise) begin
      // Unfinished readout or aborted pulse selects channel two
      second_reg <= (bits_read_reg != 4'(`RESULT_BITS));
    end
  end

  // ==========================================================
  // Track/hold and successive approximation
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held_reg    <= 12'h000;
      sar_reg     <= 12'h000;
      bit_idx_reg <= 4'h0;
    end else if (state_reg == DEV_TRACK && start_fall && !start_rise) begin
      // Positive cap minus grounded negative cap
      held_reg    <= second_reg ? i_ch2_code : i_ch1_code;
      sar_reg     <= 12'h000;
      bit_idx_reg <= 4'(`RESULT_MSB);
    end else if (int_tick) begin
      if (held_reg >= (sar_reg | (12'h001 << bit_idx_reg))) begin
        sar_reg <= sar_reg | (12'h001 << bit_idx_reg);
      end
      if (bit_idx_reg != 4'h0) begin
        bit_idx_reg <= bit_idx_reg - 4'h1;
      end
    end
  end

  // ==========================================================
  // Result capture for the user side
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_result       <= 12'h000;
      o_result_valid <= 1'b0;
    end else begin
      o_result_valid <= conv_done && !start_rise;
      if (conv_done && !start_rise) begin
        o_result <= sar_final(held_reg, sar_reg);
      end
    end
  end

  // Last trial bit folded in at completion
  function automatic result_t sar_final(input result_t held, input result_t sar);
    result_t res;
    res = sar;
    if (held >= (sar | 12'h001)) begin
      res = sar | 12'h001;
    end
    return res;
  endfunction : sar_final

  assign final_code = sar_final(held_reg, sar_reg);

  // ==========================================================
  // Serial readout
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg     <= 12'h000;
      bits_read_reg <= 4'(`RESULT_BITS);
      dout_reg      <= 1'b0;
      dout_oe_reg   <= 1'b0;
    end else if (start_rise) begin
      bits_read_reg <= 4'h0;
      dout_reg      <= 1'b0;
      dout_oe_reg   <= 1'b1;
    end else if (conv_done) begin
      shift_reg     <= final_code;
      bits_read_reg <= 4'h0;
      dout_reg      <= final_code[`RESULT_MSB];
      dout_oe_reg   <= 1'b1;
    end else if (state_reg == DEV_READOUT && bits_read_reg != 4'(`RESULT_BITS)) begin
      if (sclk_rise) begin
        bits_read_reg <= bits_read_reg + 4'h1;
        if (bits_read_reg == 4'(`RESULT_BITS - 1)) begin
          dout_oe_reg <= 1'b0;
        end
      end else if (sclk_fall && bits_read_reg != 4'h0) begin
        shift_reg <= {shift_reg[`RESULT_MSB-1:0], 1'b0};
        dout_reg  <= shift_reg[`RESULT_MSB-1];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign link.serial_data_out_o  = dout_reg;
  assign link.serial_data_out_oe = dout_oe_reg;
  assign o_tracking              = (state_reg == DEV_TRACK);
  assign o_second_channel        = second_reg;
  assign o_shutdown              = (state_reg == DEV_SHUTDOWN) || (state_reg == DEV_READOUT);

endmodule : sar_adc_device

// ==== hw/sar_adc_host.sv ====
`include "sar_adc_consts.svh"

// ==========================================================
// Result FIFO
module sar_fifo #(
  parameter int WIDTH = `RESULT_BITS,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;

  assign empty       = (wr_ptr_reg == rd_ptr_reg);
  assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (i_in_valid && !full) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (i_in_valid && !full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (i_out_ready && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : sar_fifo

// ==========================================================
// Host end: start pulses, conversion wait, serial readout
module sar_adc_host #(
  parameter int SOURCE_OHMS = 0
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  sar_link_if.host             link,
  input  wire logic            i_start,
  input  wire logic            i_second_channel,
  output logic                 o_start_ready,
  output logic                 o_busy,
  output sar_pkg::result_t     o_data,
  output logic                 o_valid,
  input  wire logic            i_ready
);
  import sar_pkg::*;

  // Acquisition from source resistance, never below the floor
  localparam int ACQ_CALC_NS = 9 * (SOURCE_OHMS + `RIN_OHMS) * `SAMPLE_CAP_PF / 1000 +
                               `PWR_UP_NS;
  localparam int ACQ_NS      = (ACQ_CALC_NS > `ACQ_MIN_NS) ? ACQ_CALC_NS : `ACQ_MIN_NS;
  localparam int ACQ_CYC     = `CYC_MIN(ACQ_NS);
  localparam int WAIT_CYC    = `CONV_MAX_CYC + `SYNC_SLACK_CYC;

  host_state_t state_reg;
  logic [15:0] timer_reg;
  logic        start_pin_reg;
  logic        sclk_reg;
  logic [3:0]  bits_reg;
  result_t     shift_reg;
  logic        dout_meta_reg;
  logic        dout_sync_reg;
  logic        fifo_in_ready;
  logic        timer_done;

  assign timer_done    = (timer_reg == 16'h0000);
  assign o_start_ready = (state_reg == HOST_IDLE);
  assign o_busy        = (state_reg != HOST_IDLE);

  // ==========================================================
  // Data pin synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_meta_reg <= 1'b0;
      dout_sync_reg <= 1'b0;
    end else begin
      dout_meta_reg <= link.serial_data_out;
      dout_sync_reg <= dout_meta_reg;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg     <= HOST_IDLE;
      timer_reg     <= 16'h0000;
      start_pin_reg <= 1'b0;
      sclk_reg      <= 1'b0;
      bits_reg      <= 4'h0;
      shift_reg     <= 12'h000;
    end else begin
      if (!timer_done) begin
        timer_reg <= timer_reg - 16'h0001;
      end
      case (state_reg)
        HOST_IDLE: begin
          if (i_start) begin
            start_pin_reg <= 1'b1;
            if (i_second_channel) begin
              timer_reg <= 16'(`PULSE_MIN_CYC - 1);
              state_reg <= HOST_PRE_HIGH;
            end else begin
              timer_reg <= 16'(ACQ_CYC - 1);
              state_reg <= HOST_ACQUIRE;
            end
          end
        end
        HOST_PRE_HIGH: begin
          if (timer_done) begin
            start_pin_reg <= 1'b0;
            timer_reg     <= 16'(`PULSE_MIN_CYC - 1);
            state_reg     <= HOST_PRE_LOW;
          end
        end
        HOST_PRE_LOW: begin
          if (timer_done) begin
            start_pin_reg <= 1'b1;
            timer_reg     <= 16'(ACQ_CYC - 1);
            state_reg     <= HOST_ACQUIRE;
          end
        end
        HOST_ACQUIRE: begin
          if (timer_done) begin
            start_pin_reg <= 1'b0;
            timer_reg     <= 16'(WAIT_CYC - 1);
            state_reg     <= HOST_CONV_WAIT;
          end
        end
        HOST_CONV_WAIT: begin
          if (timer_done) begin
            bits_reg  <= 4'h0;
            timer_reg <= 16'(`SCLK_HALF_CYC - 1);
            state_reg <= HOST_READ;
          end
        end
        HOST_READ: begin
          if (timer_done) begin
            timer_reg <= 16'(`SCLK_HALF_CYC - 1);
            if (!sclk_reg) begin
              sclk_reg  <= 1'b1;
              shift_reg <= {shift_reg[`RESULT_MSB-1:0], dout_sync_reg};
              bits_reg  <= bits_reg + 4'h1;
            end else begin
              sclk_reg <= 1'b0;
              if (bits_reg == 4'(`RESULT_BITS)) begin
                state_reg <= HOST_PUSH;
              end
            end
          end
        end
        HOST_PUSH: begin
          if (fifo_in_ready) begin
            state_reg <= HOST_IDLE;
          end
        end
        default: begin
          state_reg <= HOST_IDLE;
        end
      endcase
    end
  end

  assign link.conversion_start_pin = start_pin_reg;
  assign link.serial_clock_pin     = sclk_reg;

  sar_fifo #(
    .WIDTH (`RESULT_BITS),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (state_reg == HOST_PUSH),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (shift_reg),
    .o_out_valid (o_valid),
    .i_out_ready (i_ready),
    .o_out_data  (o_data)
  );
endmodule : sar_adc_host

// ==== sim/sar_link_assertions.sv ====
module sar_link_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic conversion_start_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ACQ_CYC  = 140;
  localparam int CONV_CYC = 370;
  logic [9:0] hi_cnt_reg;
  logic [8:0] conv_cnt_reg;
  logic [3:0] since_fall_reg;
  logic [3:0] rise_cnt_reg;
  logic       start_q_reg;
  logic       sclk_q_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // ==========================================================
  // Helper counters
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_q_reg <= 1'b0;
      sclk_q_reg  <= 1'b0;
    end else begin
      start_q_reg <= conversion_start_pin;
      sclk_q_reg  <= serial_clock_pin;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) hi_cnt_reg <= '0;
    else if (!conversion_start_pin) hi_cnt_reg <= '0;
    else if (hi_cnt_reg != 10'h3ff) hi_cnt_reg <= hi_cnt_reg + 10'h001;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) conv_cnt_reg <= '0;
    else if (start_q_reg && !conversion_start_pin) conv_cnt_reg <= 9'(CONV_CYC);
    else if (conv_cnt_reg != '0) conv_cnt_reg <= conv_cnt_reg - 9'h001;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) since_fall_reg <= 4'hf;
    else if (sclk_q_reg && !serial_clock_pin) since_fall_reg <= '0;
    else if (since_fall_reg != 4'hf) since_fall_reg <= since_fall_reg + 4'h1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) rise_cnt_reg <= '0;
    else if (!start_q_reg && conversion_start_pin) rise_cnt_reg <= '0;
    else if (!sclk_q_reg && serial_clock_pin && rise_cnt_reg != 4'hf)
      rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end

  // ==========================================================
  // Checks
  start_drive_a: assert property ($rose(conversion_start_pin) |-> ##[1:6]
    (serial_data_out_oe && !serial_data_out_o)) else $error("start rise: data not low");
  acq_high_a: assert property ($fell(conversion_start_pin) && hi_cnt_reg < ACQ_CYC
    |-> ##[1:10] $rose(conversion_start_pin)) else $error("start high too short");
  pulse_high_a: assert property ($rose(conversion_start_pin) |-> conversion_start_pin[*3])
    else $error("start high pulse short");
  pulse_low_a: assert property ($fell(conversion_start_pin) |-> !conversion_start_pin[*3])
    else $error("start low pulse short");
  sclk_quiet_a: assert property (conv_cnt_reg != '0 |-> !serial_clock_pin)
    else $error("serial clock during conversion");
  data_edge_a: assert property ($changed(serial_data_out_o) && serial_data_out_oe
    && $past(serial_data_out_oe) && conv_cnt_reg == '0 |-> since_fall_reg <= 4'h6)
    else $error("data changed away from clock fall");
  data_release_a: assert property ($rose(serial_clock_pin) && rise_cnt_reg == 4'hb
    |-> ##[1:8] !serial_data_out_oe) else $error("data not released");
  oe_hold_a: assert property ($rose(serial_clock_pin) && rise_cnt_reg < 4'hb
    |-> serial_data_out_oe[*6]) else $error("data released early");
  full_read_a: assert property ($rose(conversion_start_pin)
    |-> rise_cnt_reg inside {4'h0, 4'hc}) else $error("start before full readout");

  double_pulse_c: cover property ($fell(conversion_start_pin) ##[3:10] $rose(conversion_start_pin));
  release_c: cover property ($rose(serial_clock_pin) && rise_cnt_reg == 4'hb);
  conv_end_c: cover property (conv_cnt_reg == 9'h001);
endmodule : sar_link_assertions

// ==== sim/sar_adc_conversion_sequencer_tb.sv ====
module sar_adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sar_pkg::*;
  logic    i_clk, i_rst_n, i_start, i_second_channel, i_ready;
  logic    o_start_ready, o_busy, o_valid;
  logic    dev_tracking, dev_second, dev_shutdown, dev_valid, b_second;
  result_t ch1_code, ch2_code, o_data, dev_result;
  int      n_fail, n_checks;
  result_t exp_q[$];

  sar_link_if link ();
  sar_link_if link_b ();
  sar_adc_device u_sar_adc_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link.device),
    .i_ch1_code(ch1_code), .i_ch2_code(ch2_code), .o_tracking(dev_tracking),
    .o_second_channel(dev_second), .o_shutdown(dev_shutdown), .o_result(dev_result),
    .o_result_valid(dev_valid));
  sar_adc_host u_sar_adc_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link.host),
    .i_start(i_start), .i_second_channel(i_second_channel), .o_start_ready(o_start_ready),
    .o_busy(o_busy), .o_data(o_data), .o_valid(o_valid), .i_ready(i_ready));
  sar_adc_device u_sar_adc_device_b (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_b.device),
    .i_ch1_code(12'hb3e), .i_ch2_code(12'h4d7), .o_tracking(), .o_second_channel(b_second),
    .o_shutdown(), .o_result(), .o_result_valid());
  sar_link_assertions u_sar_link_assertions (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .conversion_start_pin(link.conversion_start_pin), .serial_clock_pin(link.serial_clock_pin),
    .serial_data_out_o(link.serial_data_out_o), .serial_data_out_oe(link.serial_data_out_oe));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ==========================================================
  // Helpers
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input result_t got, input result_t exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic timed_out(input string what);
    n_fail++;
    $display("MISMATCH %s expected event seen timeout", what);
    summarize();
  endtask : timed_out
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask : tick

  // ==========================================================
  // Host-driven conversion, device watched at its ports
  task automatic run_conv(input logic ch2, input result_t code);
    int k;
    for (k = 0; k < 2000 && o_start_ready !== 1'b1; k++) tick();
    if (o_start_ready !== 1'b1) timed_out("start ready");
    @(posedge i_clk);
    if (ch2) ch2_code <= code;
    else ch1_code <= code;
    i_start          <= 1'b1;
    i_second_channel <= ch2;
    @(posedge i_clk);
    i_start <= 1'b0;
    for (k = 0; k < 50 && dev_tracking !== 1'b1; k++) tick();
    if (dev_tracking !== 1'b1) timed_out("tracking");
    check("data low", {11'h000, link.serial_data_out}, 12'h000);
    check("busy", {11'h000, o_busy}, 12'h001);
    for (k = 0; k < 400 && !(dev_tracking === 1'b0 && k > 20); k++) tick();
    if (dev_tracking !== 1'b0) timed_out("hold");
    check("start low at hold", {11'h000, link.conversion_start_pin}, 12'h000);
    for (k = 0; k < 400 && dev_valid !== 1'b1; k++) tick();
    if (dev_valid !== 1'b1) timed_out("result");
    check("msb in time", (k < 368) ? 12'h001 : 12'h000, 12'h001);
    check("result", dev_result, code);
    check("channel", {11'h000, dev_second}, {11'h000, ch2});
    check("msb", {11'h000, link.serial_data_out}, {11'h000, code[11]});
    tick();
    check("shutdown", {11'h000, dev_shutdown}, 12'h001);
    for (k = 0; k < 1000 && link.serial_data_out_oe !== 1'b0; k++) tick();
    check("released", {11'h000, link.serial_data_out_oe}, 12'h000);
    exp_q.push_back(code);
  endtask : run_conv

  task automatic pop_all;
    int k;
    while (exp_q.size() > 0) begin
      for (k = 0; k < 2000 && o_valid !== 1'b1; k++) tick();
      if (o_valid !== 1'b1) timed_out("host word");
      check("host word", o_data, exp_q.pop_front());
      @(posedge i_clk);
      i_ready <= 1'b1;
      @(posedge i_clk);
      i_ready <= 1'b0;
      #1;
    end
  endtask : pop_all

  // ==========================================================
  // Bench-driven link for the partial readout case
  task automatic b_convert;
    @(posedge i_clk);
    link_b.conversion_start_pin <= 1'b1;
    repeat (150) @(posedge i_clk);
    link_b.conversion_start_pin <= 1'b0;
    repeat (380) @(posedge i_clk);
  endtask : b_convert
  task automatic b_read(input int n, output result_t bits);
    bits = '0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge i_clk);
      bits = {bits[10:0], link_b.serial_data_out};
      link_b.serial_clock_pin <= 1'b1;
      repeat (4) @(posedge i_clk);
      link_b.serial_clock_pin <= 1'b0;
    end
  endtask : b_read

  // ==========================================================
  // Scenarios
  task automatic s_channels;
    run_conv(1'b0, 12'ha5c);
    run_conv(1'b1, 12'h3c1);
    run_conv(1'b0, 12'h800);
    pop_all();
  endtask : s_channels
  task automatic s_fifo_full;
    run_conv(1'b0, 12'h001);
    run_conv(1'b0, 12'hfff);
    run_conv(1'b1, 12'h555);
    run_conv(1'b0, 12'haaa);
    run_conv(1'b1, 12'h7ff);
    repeat (20) tick();
    check("stalled", {11'h000, o_start_ready}, 12'h000);
    pop_all();
  endtask : s_fifo_full
  task automatic s_partial;
    result_t bits;
    b_convert();
    b_read(5, bits);
    check("partial bits", bits, 12'h016);
    b_convert();
    check("channel after partial", {11'h000, b_second}, 12'h001);
    b_read(12, bits);
    check("second code", bits, 12'h4d7);
    check("b released", {11'h000, link_b.serial_data_out_oe}, 12'h000);
    b_convert();
    check("channel after full", {11'h000, b_second}, 12'h000);
    b_read(12, bits);
    check("first code", bits, 12'hb3e);
  endtask : s_partial

  initial begin
    n_fail                      = 0;
    n_checks                    = 0;
    i_rst_n                     = 1'b0;
    i_start                     = 1'b0;
    i_second_channel            = 1'b0;
    i_ready                     = 1'b0;
    ch1_code                    = '0;
    ch2_code                    = '0;
    link_b.conversion_start_pin = 1'b0;
    link_b.serial_clock_pin     = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check("reset shutdown", {11'h000, dev_shutdown}, 12'h001);
    check("reset pin", {11'h000, link.serial_data_out_oe}, 12'h000);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    s_channels();
    s_fifo_full();
    s_partial();
    summarize();
  end
endmodule : sar_adc_conversion_sequencer_tb
